// *** csr_core_regs.sv ***
/*
  csr_core_regs: stack pointer, data pointer, accumulator and status word.
  assumes: a special-function bus of address, write strobe, write data and
  read strobe on clk; the execution datapath on the same clock drives
  flag updates, stack ops and accumulator loads as one-cycle pulses.
*/
// Functional notes
// RL1: stack pointer resets to 07h
// RL2: push increments pointer, then addresses new slot
// RL3: stack pointer is read/write at 81h
// RL4: low and high bytes form 16-bit data pointer
// RL5: carry set on carry/borrow, else cleared
// RL6: aux carry follows nibble carry or borrow
// RL7: bank select picks one of four banks
// RL8: overflow set on signed, mul, div faults
// RL9: overflow cleared otherwise by those ops
// RL10: parity is read-only accumulator odd parity
// RL11: bits 5 and 1 are free user flags
// RL12: accumulator at E0h, resets to zero
// RL13: software writes zero to reserved bits
// RL14: reserved bits reset to zero
// RL15: software avoids undefined special addresses
// RL16: pop reads at pointer, then decrements
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire csr_pkg::csr_flags_t flags_in,
  input wire csr_pkg::csr_stack_op_t stack_op,
  input wire logic accum_load,
  input wire logic [7:0] accum_value,
  output logic [7:0] stack_addr,
  output logic stack_strobe,
  output logic [15:0] data_pointer,
  output logic [7:0] accumulator,
  output logic [7:0] program_status_word,
  output logic [7:0] bank_base
);

  // architectural registers and their next values
  logic [7:0] stack_top_pointer_q;
  logic [7:0] stack_top_pointer_d;
  logic [7:0] data_pointer_low_q;
  logic [7:0] data_pointer_low_d;
  logic [7:0] data_pointer_high_q;
  logic [7:0] data_pointer_high_d;
  logic [7:0] accumulator_q;
  logic [7:0] accumulator_d;
  logic [7:0] status_q;
  logic [7:0] status_d;

  // registered side outputs and their next values
  logic [7:0] stack_addr_q;
  logic [7:0] stack_addr_d;
  logic stack_strobe_q;
  logic stack_strobe_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_q;
  logic hit_d;
  logic [7:0] bank_base_q;
  logic [7:0] bank_base_d;

  // odd parity of a byte: one when the count of ones is odd
  function automatic logic odd_parity(input logic [7:0] v);
    odd_parity = ^v;
  endfunction

  // true when the bus address names the given register
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction

  // new byte when this register is written, else the held byte
  function automatic logic [7:0] write_sel(input logic wr_en,
                                           input logic [7:0] wdata,
                                           input logic [7:0] held);
    write_sel = wr_en ? wdata : held;
  endfunction

  // first byte address of a working bank
  function automatic logic [7:0] bank_start(input logic [1:0] sel);
    bank_start = 8'({6'h00, sel} * csr_pkg::BANK_SIZE);
  endfunction

  // address decode, one select per mapped register
  wire sel_stack = addr_is(sfr_addr, csr_pkg::ADDR_STACK_TOP); // RL3
  wire sel_ptr_low = addr_is(sfr_addr, csr_pkg::ADDR_DATA_PTR_LOW); // RL4
  wire sel_ptr_high = addr_is(sfr_addr, csr_pkg::ADDR_DATA_PTR_HIGH); // RL4
  wire sel_status = addr_is(sfr_addr, csr_pkg::ADDR_STATUS);
  wire sel_accum = addr_is(sfr_addr, csr_pkg::ADDR_ACCUM); // RL12
  wire any_sel = sel_stack | sel_ptr_low | sel_ptr_high | sel_status |
                 sel_accum;

  // write enables; only a strobe with a matching address writes
  wire wr_stack = sfr_wr & sel_stack;
  wire wr_ptr_low = sfr_wr & sel_ptr_low;
  wire wr_ptr_high = sfr_wr & sel_ptr_high;
  wire wr_status = sfr_wr & sel_status;
  wire wr_accum = sfr_wr & sel_accum;

  // stack requests; push with pop, or beside a pointer write, is
  // dropped so the pointer and the datapath never disagree
  wire do_push = stack_op.push & ~stack_op.pop & ~wr_stack;
  wire do_pop = stack_op.pop & ~stack_op.push & ~wr_stack;

  // pointer arithmetic wraps inside the 8-bit space
  wire [7:0] ptr_inc = stack_top_pointer_q + 8'h01;
  wire [7:0] ptr_dec = stack_top_pointer_q - 8'h01;

  // next pointer: software write, push pre-increments, pop
  // post-decrements
  assign stack_top_pointer_d = wr_stack ? sfr_wdata : // RL3
                               do_push ? ptr_inc : // RL2
                               do_pop ? ptr_dec : // RL16
                               stack_top_pointer_q;

  // push addresses the new top, pop the current one; idle holds the
  // last address so the datapath can still use it
  assign stack_addr_d = do_push ? ptr_inc : // RL2
                        do_pop ? stack_top_pointer_q : // RL16
                        stack_addr_q;
  assign stack_strobe_d = do_push | do_pop;

  // data pointer bytes, written by software only
  assign data_pointer_low_d = write_sel(wr_ptr_low, sfr_wdata,
                                        data_pointer_low_q);
  assign data_pointer_high_d = write_sel(wr_ptr_high, sfr_wdata,
                                         data_pointer_high_q);

  // accumulator: software write over datapath load
  assign accumulator_d = wr_accum ? sfr_wdata :
                         accum_load ? accum_value : // RL12
                         accumulator_q;

  // software view of the status word before flag updates
  logic [7:0] status_sw;
  assign status_sw = write_sel(wr_status, sfr_wdata, status_q); // RL11

  // datapath flag updates beat a software write in the same cycle;
  // overflow moves only for the ops that define it
  wire flag_upd = flags_in.valid;
  wire ovf_upd = flags_in.valid & flags_in.upd_ovf;
  wire next_carry = flag_upd ? flags_in.carry : // RL5
                    status_sw[csr_pkg::BIT_CARRY];
  wire next_aux = flag_upd ? flags_in.aux : // RL6
                  status_sw[csr_pkg::BIT_AUX];
  wire next_ovf = ovf_upd ? flags_in.ovf : // RL8 RL9
                  status_sw[csr_pkg::BIT_OVF];

  // software-only fields: user flags and bank select
  wire user_a = status_sw[csr_pkg::BIT_USER_A]; // RL11
  wire user_b = status_sw[csr_pkg::BIT_USER_B]; // RL11
  wire bank_hi = status_sw[csr_pkg::BIT_BANK_HI]; // RL7
  wire bank_lo = status_sw[csr_pkg::BIT_BANK_LO]; // RL7

  // parity follows the next accumulator, so a write to it is lost
  // and it always matches the accumulator shown in the same cycle
  wire next_parity = odd_parity(accumulator_d); // RL10

  // status word assembled from its fields, carry in the top bit
  assign status_d = {next_carry,
                     next_aux,
                     user_a,
                     bank_hi,
                     bank_lo,
                     next_ovf,
                     user_b,
                     next_parity};

  // bank base follows the next bank select, in step with the status
  wire [1:0] bank_sel = {bank_hi, bank_lo};
  assign bank_base_d = bank_start(bank_sel); // RL7

  // read mux; no strobe or an unmapped address reads zero
  assign rdata_d = !sfr_rd ? 8'h00 :
                   sel_stack ? stack_top_pointer_q :
                   sel_ptr_low ? data_pointer_low_q :
                   sel_ptr_high ? data_pointer_high_q :
                   sel_status ? status_q :
                   sel_accum ? accumulator_q : 8'h00;

  // hit: a strobe met one of the five mapped addresses
  assign hit_d = (sfr_rd | sfr_wr) & any_sel;

  // stack pointer register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_top_pointer_q <= csr_pkg::RST_STACK_TOP; // RL1
    end else begin
      stack_top_pointer_q <= stack_top_pointer_d;
    end
  end

  // data pointer low byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_pointer_low_q <= csr_pkg::RST_DATA_PTR;
    end else begin
      data_pointer_low_q <= data_pointer_low_d;
    end
  end

  // data pointer high byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_pointer_high_q <= csr_pkg::RST_DATA_PTR;
    end else begin
      data_pointer_high_q <= data_pointer_high_d;
    end
  end

  // accumulator register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accumulator_q <= csr_pkg::RST_ACCUM; // RL12
    end else begin
      accumulator_q <= accumulator_d;
    end
  end

  // status word; every bit, reserved meaning or not, clears at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= csr_pkg::RST_STATUS; // RL14
    end else begin
      status_q <= status_d;
    end
  end

  // stack address toward the datapath
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_addr_q <= csr_pkg::RST_STACK_TOP;
    end else begin
      stack_addr_q <= stack_addr_d;
    end
  end

  // one-cycle stack strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_strobe_q <= 1'b0;
    end else begin
      stack_strobe_q <= stack_strobe_d;
    end
  end

  // registered read data, zero outside a read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // registered address hit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  // working bank base address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_base_q <= 8'h00;
    end else begin
      bank_base_q <= bank_base_d;
    end
  end

  // outputs straight from flops
  assign sfr_rdata = rdata_q;
  assign sfr_hit = hit_q;
  assign stack_addr = stack_addr_q;
  assign stack_strobe = stack_strobe_q;
  assign data_pointer = {data_pointer_high_q, data_pointer_low_q}; // RL4
  assign accumulator = accumulator_q;
  assign program_status_word = status_q;
  assign bank_base = bank_base_q;

endmodule
`default_nettype wire

// *** csr_core_regs_sva.sv ***
/* checker on the csr_core_regs ports.
   assumes: bound to the design, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire csr_pkg::csr_flags_t flags_in,
  input wire csr_pkg::csr_stack_op_t stack_op,
  input wire logic accum_load,
  input wire logic [7:0] accum_value,
  input wire logic [7:0] stack_addr,
  input wire logic stack_strobe,
  input wire logic [15:0] data_pointer,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] program_status_word,
  input wire logic [7:0] bank_base
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // lone stack requests with no software write beside them
  sequence push_s; stack_op == 2'b10 && !sfr_wr; endsequence
  sequence pop_s; stack_op == 2'b01 && !sfr_wr; endsequence
  parity_ro_a: assert property (
    program_status_word[0] == ^accumulator) else $error("parity");
  bank_map_a: assert property (
    bank_base == {3'h0, program_status_word[4:3], 3'h0}) else $error("bank");
  carry_upd_a: assert property (flags_in.valid |=>
    program_status_word[7] == $past(flags_in.carry)) else $error("carry");
  ovf_upd_a: assert property (flags_in.valid && flags_in.upd_ovf |=>
    program_status_word[2] == $past(flags_in.ovf)) else $error("ovf");
  push_inc_a: assert property (push_s ##1 push_s |=>
    stack_strobe && stack_addr == $past(stack_addr) + 8'h01) else $error("push");
  pop_hold_a: assert property (push_s ##1 pop_s |=>
    stack_strobe && $stable(stack_addr)) else $error("pop");
  ptr_write_a: assert property ((sfr_wr && sfr_addr == 8'h81) ##1 push_s |=>
    stack_addr == $past(sfr_wdata, 2) + 8'h01) else $error("pointer write");
  accum_load_a: assert property (accum_load && !sfr_wr |=>
    accumulator == $past(accum_value)) else $error("accum load");
  data_high_a: assert property (sfr_wr && sfr_addr == 8'h83 |=>
    data_pointer[15:8] == $past(sfr_wdata)) else $error("data pointer");
endmodule
bind csr_core_regs csr_core_regs_sva u_sva (.clk, .reset_n, .sfr_addr,
  .sfr_wr, .sfr_wdata, .flags_in, .stack_op, .accum_load, .accum_value,
  .stack_addr, .stack_strobe, .data_pointer, .accumulator,
  .program_status_word, .bank_base);
`default_nettype wire

// *** csr_dp_model.sv ***
/* csr_dp_model: adder of the datapath, gives flags and accumulator load.
   assumes: go is a one-cycle pulse on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module csr_dp_model (
  input wire logic go,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  output var csr_pkg::csr_flags_t flags,
  output logic accum_load,
  output logic [7:0] accum_value
);
  // sum, nibble carry and signed overflow of an add
  wire logic [8:0] sum = {1'b0, op_a} + {1'b0, op_b};
  wire logic [4:0] nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  wire logic ovf = op_a[7] == op_b[7] && sum[7] != op_a[7];
  assign flags = '{go, 1'b1, sum[8], nib[4], ovf};
  assign accum_load = go;
  assign accum_value = sum[7:0];
endmodule
`default_nettype wire

// *** csr_pkg.sv ***
/*
  csr_pkg: constants and carrier types for the core special registers.
  assumes: included before csr_core_regs; its checker, the datapath model and the bench depend on it too.
*/
`default_nettype none
package csr_pkg;
  // special-function addresses
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_DATA_PTR_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_PTR_HIGH = 8'h83;
  localparam logic [7:0] ADDR_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;
  // reset values
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_DATA_PTR = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  // status word bit positions
  localparam int BIT_CARRY = 7;
  localparam int BIT_AUX = 6;
  localparam int BIT_USER_A = 5;
  localparam int BIT_BANK_HI = 4;
  localparam int BIT_BANK_LO = 3;
  localparam int BIT_OVF = 2;
  localparam int BIT_USER_B = 1;
  localparam int BIT_PARITY = 0;
  localparam logic [7:0] BANK_SIZE = 8'h08;

  // arithmetic flag update from the datapath
  typedef struct packed {
    logic valid;         // one-cycle: an arithmetic op completed
    logic upd_ovf;       // op is add/addc/subb/mul/div
    logic carry;         // carry out or borrow
    logic aux;           // nibble carry or borrow
    logic ovf;           // signed overflow, mul > 255, div by zero
  } csr_flags_t;

  // stack operation request from the datapath
  typedef struct packed {
    logic push;
    logic pop;
  } csr_stack_op_t;
endpackage
`default_nettype wire

// *** tb_top.sv ***
/* tb_top: self-checking bench for csr_core_regs.
   assumes: package, datapath model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, go = 0, accum_load;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, op_a = 0, op_b = 0, accum_value;
  logic [7:0] sfr_rdata, stack_addr, accumulator, program_status_word;
  logic [7:0] bank_base, rv;
  logic [15:0] data_pointer;
  logic sfr_hit, stack_strobe, rh;
  csr_pkg::csr_flags_t flags_in;
  csr_pkg::csr_stack_op_t stack_op = '0;
  int n_errors = 0, tests_run = 0;
  // rows: write flag, address, write data, expected read
  logic [24:0] rows [8] = '{{1'b0, 8'h81, 8'h00, 8'h07},
    {1'b0, 8'hE0, 8'h00, 8'h00}, {1'b1, 8'h81, 8'h5A, 8'h5A},
    {1'b1, 8'h82, 8'h34, 8'h34}, {1'b1, 8'h83, 8'h12, 8'h12},
    {1'b1, 8'hE0, 8'h07, 8'h07}, {1'b1, 8'hD0, 8'h22, 8'h23},
    {1'b1, 8'h80, 8'h55, 8'h00}};
  csr_core_regs dut (.clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rd, .sfr_rdata, .sfr_hit, .flags_in, .stack_op, .accum_load,
    .accum_value, .stack_addr, .stack_strobe, .data_pointer, .accumulator,
    .program_status_word, .bank_base);
  csr_dp_model dp (.go, .op_a, .op_b, .flags(flags_in), .accum_load,
    .accum_value);
  always #10 clk = ~clk;
  // bus helpers: drive 1 ns after the edge, then one idle cycle so a
  // strobe never rises in the step in which it fell
  task tick; @(posedge clk); #1; endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1; sfr_addr = a; sfr_wdata = d; tick; sfr_wr = 0; tick;
  endtask
  task rd(input logic [7:0] a);
    sfr_rd = 1; sfr_addr = a; tick; sfr_rd = 0; rv = sfr_rdata; rh = sfr_hit;
    tick;
  endtask
  task add(input logic [7:0] a, input logic [7:0] b);
    go = 1; op_a = a; op_b = b; tick; go = 0; tick;
  endtask
  // stack ops run back to back; the last one releases and idles
  task stk(input logic [1:0] op, input bit last);
    stack_op = op; tick;
    if (last) begin
      stack_op = '0; tick;
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence: table, banks, stack, flags, second reset
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1;
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(rv, rows[i][7:0]);
      chk(rh, rows[i][23:16] != 8'h80);
    end
    chk(data_pointer, 16'h1234);
    for (int b = 0; b < 4; b++) begin
      wr(8'hD0, 8'(b << 3));
      chk(bank_base, 8'(b * 8));
    end
    sfr_wr = 1; sfr_addr = 8'h81; sfr_wdata = 8'h20; tick; sfr_wr = 0;
    stk(2'b10, 0);
    chk(stack_addr, 8'h21);
    chk(stack_strobe, 1'b1);
    stk(2'b10, 0);
    stk(2'b01, 1);
    chk(stack_addr, 8'h22);
    chk(stack_strobe, 1'b0);
    stk(2'b11, 1);
    rd(8'h81);
    chk(rv, 8'h21);
    wr(8'hD0, 8'h00);
    add(8'h7F, 8'h01);
    chk(program_status_word, 8'h45);
    chk(accumulator, 8'h80);
    add(8'hFF, 8'h01);
    chk(program_status_word, 8'hC0);
    wr(8'hD0, 8'h01);
    chk(program_status_word, 8'h00);
    reset_n = 0;
    tick;
    reset_n = 1;
    rd(8'h81);
    chk(rv, 8'h07);
    chk(stack_addr, 8'h07);
    chk(program_status_word, 8'h00);
    chk(data_pointer, 16'h0000);
    give_verdict;
  end
  // watchdog well past the roughly seventy cycles the run needs
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
